// ---- flash_host.sv ----
/*
  Host controller driving a parallel NOR flash: single bus cycles and toggle polling.
  Assumes Avalon-MM master on clock, flash pins asynchronous to clock.
*/
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"
module flash_host import flash_host_pkg::*; #(
  parameter int AW = 22
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  output logic [AW-1:0] flashAddr,
  output logic [15:0] dataOut,
  output logic dataOutEnN,
  input wire logic [15:0] dataIn,
  output logic chipSelN,
  output logic writeEnN,
  output logic outEnN,
  output logic resetN,
  output logic wordMode,
  input wire logic readyBusyIn
);
  localparam logic [7:0] STROBE = 8'(`STROBE_CYC);
  logic [15:0] dinS1, dinS2;
  logic rbS1, rbS2;
  state_t st_reg, st_next;
  op_t op_reg, op_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next, first_reg, first_next;
  logic word_reg, word_next, busy_reg, busy_next, done_reg, done_next;
  logic fail_reg, fail_next, recheck_reg, recheck_next;
  logic cs_reg, cs_next, we_reg, we_next, oe_reg, oe_next, den_reg, den_next;
  logic rst_reg, rst_next;
  logic [31:0] rd_reg, rd_next;
  logic wait_reg, wait_next;
  logic tLoad, tDone;

  strobe_timer #(.W(8)) timer (
    .clock(clock), .rst(rst), .load(tLoad), .count(STROBE), .done(tDone)
  );

  // Toggle flag in bit 6 changed between two status reads
  function automatic logic toggled(input logic [15:0] a, input logic [15:0] b);
    return (a[6] != b[6]);
  endfunction

  always_ff @(posedge clock) begin
    dinS1 <= dataIn;
    dinS2 <= dinS1;
    rbS1 <= readyBusyIn;
    rbS2 <= rbS1;
  end

  // Bus slave and sequencer
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    first_next = first_reg;
    word_next = word_reg;
    busy_next = busy_reg;
    done_next = done_reg;
    fail_next = fail_reg;
    recheck_next = recheck_reg;
    cs_next = cs_reg;
    we_next = we_reg;
    oe_next = oe_reg;
    den_next = den_reg;
    rst_next = 1'b1;
    rd_next = rd_reg;
    wait_next = 1'b1;
    tLoad = 1'b0;
    if ((avsRead || avsWrite) && wait_reg) begin
      wait_next = 1'b0;
    end
    // Write lands at the edge that sees waitrequest low
    if (avsWrite && !wait_reg) begin
      begin
        unique case (avsAddress)
          `REG_CTRL: begin
            word_next = avsWriteData[`CTRL_WORD];
            if (avsWriteData[`CTRL_GO] && !busy_reg) begin
              op_next = op_t'(avsWriteData[`CTRL_OP_MSB:`CTRL_OP_LSB]);
              busy_next = 1'b1;
              done_next = 1'b0;
              fail_next = 1'b0;
              recheck_next = 1'b0;
              st_next = S_SETUP;
            end
          end
          `REG_ADDR: addr_next = avsWriteData[AW-1:0];
          `REG_WDATA: wdata_next = avsWriteData[15:0];
          default: ;
        endcase
      end
    end
    if (avsRead && !avsWrite && wait_reg) begin
      begin
        unique case (avsAddress)
          `REG_STATUS: begin
            rd_next = 32'h0;
            rd_next[`ST_BUSY] = busy_reg;
            rd_next[`ST_DONE] = done_reg;
            rd_next[`ST_FAIL] = fail_reg;
            rd_next[`ST_RDY] = rbS2;
            rd_next[`ST_ERWIN] = rdata_reg[3];
            rd_next[31:`ST_RDATA_LSB] = rdata_reg;
          end
          `REG_ADDR: rd_next = 32'(addr_reg);
          `REG_WDATA: rd_next = {16'h0, wdata_reg};
          `REG_CTRL: rd_next = {28'h0, word_reg, 3'h0};
          default: rd_next = 32'h0;
        endcase
      end
    end
    unique case (st_reg)
      S_IDLE: ;
      S_SETUP: begin
        cs_next = 1'b0;
        if (op_reg == OP_RESET) begin
          rst_next = 1'b0;
          tLoad = 1'b1;
          st_next = S_HOLD;
        end else if (op_reg == OP_WRITE) begin
          oe_next = 1'b1;
          we_next = 1'b0;
          den_next = 1'b0;
          tLoad = 1'b1;
          st_next = S_STROBE;
        end else begin
          oe_next = 1'b0;
          tLoad = 1'b1;
          st_next = S_RD1;
        end
      end
      S_STROBE: if (tDone) begin
        we_next = 1'b1;
        tLoad = 1'b1;
        st_next = S_HOLD;
      end
      S_HOLD: begin
        if (op_reg == OP_RESET) begin
          rst_next = tDone;
        end
        if (tDone) begin
          cs_next = 1'b1;
          den_next = 1'b1;
          st_next = S_DONE;
        end
      end
      S_RD1: if (tDone) begin
        rdata_next = dinS2;
        first_next = dinS2;
        oe_next = 1'b1;
        cs_next = 1'b1;
        if (op_reg == OP_READ) begin
          st_next = S_DONE;
        end else begin
          tLoad = 1'b1;
          st_next = S_RD2;
        end
      end
      S_RD2: begin
        cs_next = 1'b0;
        oe_next = 1'b0;
        if (tDone) begin
          tLoad = 1'b1;
          st_next = S_RD3;
        end
      end
      S_RD3: if (tDone) begin
        rdata_next = dinS2;
        oe_next = 1'b1;
        cs_next = 1'b1;
        if (!toggled(first_reg, dinS2)) begin
          st_next = S_DONE;
        end else if (dinS2[5] && recheck_reg) begin
          fail_next = 1'b1;
          st_next = S_DONE;
        end else begin
          recheck_next = dinS2[5];
          first_next = dinS2;
          tLoad = 1'b1;
          st_next = S_RD2;
        end
      end
      S_DONE: begin
        busy_next = 1'b0;
        done_next = 1'b1;
        st_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= S_IDLE;
      op_reg <= OP_READ;
      addr_reg <= '0;
      wdata_reg <= 16'h0;
      rdata_reg <= 16'h0;
      first_reg <= 16'h0;
      word_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      recheck_reg <= 1'b0;
      cs_reg <= 1'b1;
      we_reg <= 1'b1;
      oe_reg <= 1'b1;
      den_reg <= 1'b1;
      rst_reg <= 1'b1;
      rd_reg <= 32'h0;
      wait_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      first_reg <= first_next;
      word_reg <= word_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      recheck_reg <= recheck_next;
      cs_reg <= cs_next;
      we_reg <= we_next;
      oe_reg <= oe_next;
      den_reg <= den_next;
      rst_reg <= rst_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
    end
  end

  assign avsReadData = rd_reg;
  assign avsWaitRequest = wait_reg;
  assign flashAddr = addr_reg;
  assign dataOut = wdata_reg;
  assign dataOutEnN = den_reg;
  assign chipSelN = cs_reg;
  assign writeEnN = we_reg;
  assign outEnN = oe_reg;
  assign resetN = rst_reg;
  assign wordMode = word_reg;

  writeGate_a: assert property (@(posedge clock) disable iff (rst)
    !writeEnN |-> (!chipSelN && outEnN)) else $error("write strobe without select");
  addrStable_a: assert property (@(posedge clock) disable iff (rst)
    !chipSelN && $past(!chipSelN) |-> $stable(flashAddr)) else $error("address moved");
  failCause_a: assert property (@(posedge clock) disable iff (rst)
    $rose(fail_reg) |-> $past(recheck_reg)) else $error("fail without recheck");
  strobeLen_a: assert property (@(posedge clock) disable iff (rst)
    $fell(writeEnN) |-> !writeEnN [*5]) else $error("write strobe short");
  noDrive_a: assert property (@(posedge clock) disable iff (rst)
    !outEnN |-> dataOutEnN) else $error("bus contention");
  waitPulse_a: assert property (@(posedge clock) disable iff (rst)
    !avsWaitRequest |=> avsWaitRequest) else $error("waitrequest stuck low");
  resetLow_a: assert property (@(posedge clock) disable iff (rst)
    $fell(resetN) |-> ##[1:10] resetN) else $error("reset pulse unbounded");
  goneIdle_a: assert property (@(posedge clock) disable iff (rst)
    $rose(done_reg) |-> chipSelN && !busy_reg) else $error("done while selected");
endmodule // flash_host
`default_nettype wire

// ---- flash_host_bench.sv ----
/*
  Self-checking bench for the flash host with a behavioural flash.
  Assumes flash_host_regs.svh in the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"
module flash_host_bench;
  import flash_host_pkg::*;
  logic clock, rst, avsRead, avsWrite, avsWaitRequest, dataOutEnN, chipSelN, writeEnN;
  logic outEnN, resetN, wordMode, readyBusyIn, devDrive, readyBusyLow, tb;
  logic [3:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, st;
  logic [21:0] flashAddr;
  logic [15:0] dataOut, dataIn, devData;
  int miscompares = 0, checkCount = 0, cycles = 0;
  assign dataIn = !dataOutEnN ? dataOut : devDrive ? devData : clock ? 16'h5A3C : 16'hA5C3;
  assign readyBusyIn = readyBusyLow ? 1'b0 : 1'b1;
  flash_host #(.AW(22)) flash_host_i (.clock(clock), .rst(rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .flashAddr(flashAddr),
    .dataOut(dataOut), .dataOutEnN(dataOutEnN), .dataIn(dataIn), .chipSelN(chipSelN),
    .writeEnN(writeEnN), .outEnN(outEnN), .resetN(resetN), .wordMode(wordMode),
    .readyBusyIn(readyBusyIn));
  flash_model #(.AW(22)) flash_model_i (.addr(flashAddr), .dataIn(dataIn),
    .chipSelN(chipSelN), .writeEnN(writeEnN), .outEnN(outEnN), .resetN(resetN),
    .wordMode(wordMode), .devData(devData), .devDrive(devDrive),
    .readyBusyLow(readyBusyLow));
  initial clock = 1'b0;
  always #5 clock = ~clock;
  task completeRun();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      completeRun();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount = checkCount + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task checkBit(input logic seen, input logic exp);
    check({31'h00000000, seen}, {31'h00000000, exp});
  endtask
  task busWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= 1'b1;
    do @(posedge clock); while (avsWaitRequest !== 1'b0);
    avsWrite <= 1'b0;
  endtask
  task busRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsRead <= 1'b1;
    do @(posedge clock); while (avsWaitRequest !== 1'b0);
    d = avsReadData;
    avsRead <= 1'b0;
  endtask
  task flashOp(input op_t op, input logic [21:0] a, input logic [15:0] d);
    busWrite(`REG_ADDR, {10'h000, a});
    busWrite(`REG_WDATA, {16'h0000, d});
    busWrite(`REG_CTRL, {28'h0000000, 1'b1, op, 1'b1});
    do busRead(`REG_STATUS, st); while (st[`ST_BUSY] !== 1'b0);
  endtask
  task readyIs(input logic exp);
    busRead(`REG_STATUS, st);
    checkBit(st[`ST_RDY], exp);
  endtask
  task unlock();
    flashOp(OP_WRITE, 22'h000555, 16'h12AA);
    flashOp(OP_WRITE, 22'h0002AA, 16'h3455);
  endtask
  initial begin
    rst = 1'b1;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h00000000;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    busRead(`REG_CTRL, st);
    check(st, `CTRL_RESET_VAL);
    busRead(4'h6, st);
    check(st, 32'h00000000);
    readyIs(1'b1);
    $display("reset test done");
    unlock();
    flashOp(OP_WRITE, 22'h000555, 16'h00A0);
    readyIs(1'b1);
    flashOp(OP_WRITE, 22'h000003, 16'h00F0);
    readyIs(1'b0);
    checkBit(wordMode, 1'b1);
    flashOp(OP_READ, 22'h000003, 16'h0000);
    checkBit(st[23], 1'b0);
    flashOp(OP_POLL, 22'h000003, 16'h0000);
    check(st[`ST_FAIL:`ST_DONE], 32'h1);
    flashOp(OP_READ, 22'h000003, 16'h0000);
    check(st[31:16], 32'h00F0);
    readyIs(1'b1);
    $display("program test done");
    unlock();
    flashOp(OP_WRITE, 22'h000555, 16'h00A0);
    flashOp(OP_WRITE, 22'h000003, 16'h0F00);
    flashOp(OP_POLL, 22'h000003, 16'h0000);
    check(st[`ST_FAIL:`ST_DONE], 32'h3);
    flashOp(OP_READ, 22'h000003, 16'h0000);
    checkBit(st[21], 1'b1);
    flashOp(OP_RESET, 22'h000000, 16'h0000);
    readyIs(1'b1);
    flashOp(OP_READ, 22'h000003, 16'h0000);
    check(st[31:16], 32'h00F0);
    $display("failure test done");
    unlock();
    flashOp(OP_WRITE, 22'h000555, 16'h0080);
    unlock();
    readyIs(1'b1);
    flashOp(OP_WRITE, 22'h000003, 16'h0030);
    readyIs(1'b0);
    flashOp(OP_READ, 22'h000003, 16'h0000);
    checkBit(st[23], 1'b0);
    checkBit(st[`ST_ERWIN], 1'b0);
    tb = st[18];
    flashOp(OP_READ, 22'h000003, 16'h0000);
    checkBit(st[`ST_ERWIN], 1'b1);
    checkBit(st[18], ~tb);
    flashOp(OP_POLL, 22'h000003, 16'h0000);
    check(st[`ST_FAIL:`ST_DONE], 32'h1);
    flashOp(OP_READ, 22'h000003, 16'h0000);
    check(st[31:16], 32'hFFFF);
    readyIs(1'b1);
    $display("erase test done");
    completeRun();
  end
endmodule // flash_host_bench
`default_nettype wire

// ---- flash_host_pkg.sv ----
/*
  Types for the flash host controller.
  Assumes flash_host_regs.svh is in the include path.
*/
package flash_host_pkg;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_POLL, OP_RESET} op_t;
  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RD1, S_RD2, S_RD3, S_DONE} state_t;
endpackage

// ---- flash_host_regs.svh ----
/*
  Register map, field positions, reset values and timing counts for the flash host.
  Assumes inclusion by the host and bench modules; holds definitions only.
*/
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_STATUS 4'hC
`define CTRL_GO 0
`define CTRL_OP_LSB 1
`define CTRL_OP_MSB 2
`define CTRL_WORD 3
`define CTRL_RESET_VAL 32'h0000_0000
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_RDY 3
`define ST_ERWIN 4
`define ST_RDATA_LSB 16
`define T_STROBE_NS 50
`define CLK_NS 10
`define STROBE_CYC ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- flash_model.sv ----
/*
  Behavioural NOR flash: command decode, status flags, ready/busy pin.
  Assumes word mode, one sector of 16 words, and the bench resolving the bus.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_model #(
  parameter int AW = 22,
  parameter int BUSY_READS = 3,
  parameter int WIN_READS = 1
) (
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] dataIn,
  input wire logic chipSelN,
  input wire logic writeEnN,
  input wire logic outEnN,
  input wire logic resetN,
  input wire logic wordMode,
  output logic [15:0] devData,
  output logic devDrive,
  output logic readyBusyLow
);
  logic [15:0] mem [16];
  logic [15:0] progData;
  logic [3:0] progAddr;
  logic [7:0] c;
  logic armed, togA, togB;
  int mode, step, left, winCnt;
  wire logic wrAct = !chipSelN && !writeEnN && outEnN;
  wire logic rdAct = !chipSelN && !outEnN && resetN;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    mode = 0;
    step = 0;
    armed = 1'b0;
    togA = 1'b0;
    togB = 1'b0;
    devData = 16'h0000;
  end
  assign devDrive = rdAct && wordMode;
  assign readyBusyLow = (mode != 0) || !resetN;
  // Strobes first seen high arm the decoder
  always @(posedge chipSelN or posedge writeEnN) armed = 1'b1;
  // Interrupted work is dropped, never reported done
  always @(negedge resetN) begin
    mode = 0;
    step = 0;
  end
  always @(negedge wrAct) begin
    c = dataIn[7:0];
    if (armed && mode == 0) begin
      case (step)
        0, 3: step = (c == 8'hAA && addr[11:0] == 12'h555) ? step + 1 : 0;
        1, 4: step = (c == 8'h55 && addr[11:0] == 12'h2AA) ? step + 1 : 0;
        2: step = (c == 8'hA0) ? 6 : (c == 8'h80) ? 3 : 0;
        5: begin
          mode = (c == 8'h30) ? 2 : 0;
          left = BUSY_READS;
          winCnt = 0;
          step = 0;
        end
        default: begin
          progData = dataIn;
          progAddr = addr[3:0];
          mode = ((~mem[progAddr] & dataIn) != 16'h0000) ? 3 : 1;
          left = BUSY_READS;
          step = 0;
        end
      endcase
    end else if (mode == 3 && c == 8'hF0) begin
      mode = 0;
    end
  end
  always @(posedge rdAct) begin
    if (mode == 0) begin
      devData = mem[addr[3:0]];
    end else begin
      togA = !togA;
      togB = !togB;
      devData = {8'h00, (mode == 2) ? 1'b0 : ~progData[7], togA, mode == 3, 1'b0,
        mode == 2 && winCnt >= WIN_READS, (mode == 2) ? togB : 1'b1, 2'b00};
      winCnt = winCnt + 1;
      if (mode != 3) begin
        left = left - 1;
        if (left == 0 && mode == 1) mem[progAddr] = progData;
        if (left == 0 && mode == 2) foreach (mem[i]) mem[i] = 16'hFFFF;
        if (left == 0) mode = 0;
      end
    end
  end
endmodule // flash_model
`default_nettype wire

// ---- strobe_timer.sv ----
/*
  Down counter giving one-cycle done pulse after a loaded count.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module strobe_timer #(parameter int W = 8) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (load) begin
      cnt_next = count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
      done_next = (cnt_reg == {{(W-1){1'b0}}, 1'b1});
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end
  assign done = done_reg;
endmodule // strobe_timer
`default_nettype wire
